/* File: hdl/vsc_defs.svh */
// register indices, field positions, reset values and fixed counts of the video scaler
`ifndef VSC_DEFS_SVH
`define VSC_DEFS_SVH

// byte address of a register is four times its index
`define VSC_IDX_CROP 6'h03
`define VSC_IDX_VDL 6'h04
`define VSC_IDX_VAL 6'h05
`define VSC_IDX_HDL 6'h06
`define VSC_IDX_HAL 6'h07
`define VSC_IDX_HRH 6'h08
`define VSC_IDX_HRL 6'h09
`define VSC_IDX_VRH 6'h13
`define VSC_IDX_VRL 6'h14
`define VSC_IDX_VTC 6'h1A
`define VSC_IDX_SCL 6'h1B
`define VSC_IDX_STAT 6'h1C

// window_upper_bits layout
`define VSC_CROP_VDL_MSB 7
`define VSC_CROP_VDL_LSB 6
`define VSC_CROP_VAL_MSB 5
`define VSC_CROP_VAL_LSB 4
`define VSC_CROP_HDL_MSB 3
`define VSC_CROP_HDL_LSB 2
`define VSC_CROP_HAL_MSB 1
`define VSC_CROP_HAL_LSB 0

// vert_ratio_high: bits 4:0 ratio, bits 6:5 mode controls
`define VSC_VRH_RATIO_MSB 4
`define VSC_VRH_INT_BIT 5
`define VSC_VRH_ALIGN_BIT 6
`define VSC_VTC_TAP_MSB 1
`define VSC_VTC_TAP_LSB 0
`define VSC_SCL_PEAK_BIT 7
`define VSC_SCL_HF_MSB 4
`define VSC_SCL_HF_LSB 3

`define VSC_RST_BYTE 8'h00
`define VSC_HUNIT 18'h0_1000
`define VSC_VUNIT 15'h0200
`define VSC_VHALF 15'h0100
`define VSC_LS_DEPTH 2048
`define VSC_LS_LINES 4
`define VSC_HCNT_MAX 11'h7FF
`define VSC_VLINE_MAX 10'h3FF
`define VSC_RESP_OKAY 2'h0
`define VSC_RESP_SLVERR 2'h2

`endif

/* File: hdl/vsc_pkg.sv */
// types shared by the video scaler and cropper
package vsc_pkg;

	typedef struct packed {
		logic [7:0] y;
		logic [7:0] c;
	} vsc_pix_type;

	typedef enum logic [1:0] {
		VSC_VM_FRAME,
		VSC_VM_INTERLACED,
		VSC_VM_ALIGNED
	} vsc_vmode_type;

endpackage : vsc_pkg

/* File: hdl/vsc_scaler.sv */
// video down-scaler and cropper with an AXI4-Lite register slave
//
// The implementer's own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`include "vsc_defs.svh"

// How it works
// - scale down arbitrarily to 16:1 each way; 8:1 vertically from fields
// - interlaced bit: only one field is delayed and averaged by one line
// - field-align bit without interlaced: both fields filtered alike and aligned
// - selectable luma low-pass pre-filter ahead of horizontal scaling
// - horizontal luma interpolation uses 32 phases
// - vertical luma filter uses a line store, 2 to 5 taps selectable
// - vertical interpolation places lines for non-integer ratios
// - four peaking levels from peak bit and horizontal filter bits
// - horizontal chroma uses a 2-tap 32-phase interpolator
// - vertical chroma is a line-store comb then line dropping
// - unscaled NTSC gives 910 output pixels per line at pixel rate
// - horizontal ratio is the high and low bytes joined into 16 bits
// - vertical ratio is 13-bit negative two's complement; zero means unscaled
// - vertical ratio is high byte bits 4:0 plus the low byte
// - vertical window follows field start, horizontal follows line start
// - four 10-bit window values: two bits shared, eight bits each own
// - offsets place the window, width and height size it
// - horizontal counted in scaled pixels, vertical in unscaled half lines
// - vertical offset counts half lines from field start
// - width gives the number of captured pixels per line
module vsc_scaler (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [7:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	input wire logic in_valid,
	input wire vsc_pkg::vsc_pix_type in_pix,
	input wire logic line_start_strobe,
	input wire logic field_start_strobe,
	input wire logic field_odd,
	output vsc_pkg::vsc_pix_type out_pix,
	output logic out_valid,
	output logic out_line_start,
	output logic out_field_start
);

	// ****************************************
	// register slave
	// ****************************************
	logic aw_held_r, w_held_r, w_lane_r, do_write, wr_ok, rd_ok;
	logic [5:0] aw_idx_r;
	logic [7:0] w_byte_r;
	logic [31:0] rd_word;
	logic [7:0] crop_r, vdl_r, val_r, hdl_r, hal_r, hrh_r, hrl_r, vrh_r, vrl_r;
	logic [7:0] video_timing_ctrl_r, subcarrier_loop_ctrl_r;
	logic [9:0] vline_r;
	logic line_keep_r, field_odd_r;

	assign do_write = aw_held_r && w_held_r && !bvalid;
	assign wr_ok = (aw_idx_r inside {`VSC_IDX_CROP, `VSC_IDX_VDL, `VSC_IDX_VAL, `VSC_IDX_HDL,
		`VSC_IDX_HAL, `VSC_IDX_HRH, `VSC_IDX_HRL, `VSC_IDX_VRH, `VSC_IDX_VRL,
		`VSC_IDX_VTC, `VSC_IDX_SCL});

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_r <= 1'b0;
			w_held_r <= 1'b0;
			aw_idx_r <= 6'h00;
			w_byte_r <= 8'h00;
			w_lane_r <= 1'b0;
			awready <= 1'b0;
			wready <= 1'b0;
			bvalid <= 1'b0;
			bresp <= `VSC_RESP_OKAY;
		end else begin
			if (awvalid && awready) begin
				aw_held_r <= 1'b1;
				aw_idx_r <= awaddr[7:2];
			end else if (do_write) begin
				aw_held_r <= 1'b0;
			end
			if (wvalid && wready) begin
				w_held_r <= 1'b1;
				w_byte_r <= wdata[7:0];
				w_lane_r <= wstrb[0];
			end else if (do_write) begin
				w_held_r <= 1'b0;
			end
			awready <= do_write || (!aw_held_r && !(awvalid && awready));
			wready <= do_write || (!w_held_r && !(wvalid && wready));
			if (do_write) begin
				bvalid <= 1'b1;
				bresp <= wr_ok ? `VSC_RESP_OKAY : `VSC_RESP_SLVERR;
			end else if (bready && bvalid) begin
				bvalid <= 1'b0;
			end
		end
	end

	// only byte lane 0 carries data; other lanes are ignored
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			crop_r <= `VSC_RST_BYTE;
			vdl_r <= `VSC_RST_BYTE;
			val_r <= `VSC_RST_BYTE;
			hdl_r <= `VSC_RST_BYTE;
			hal_r <= `VSC_RST_BYTE;
			hrh_r <= `VSC_RST_BYTE;
			hrl_r <= `VSC_RST_BYTE;
			vrh_r <= `VSC_RST_BYTE;
			vrl_r <= `VSC_RST_BYTE;
			video_timing_ctrl_r <= `VSC_RST_BYTE;
			subcarrier_loop_ctrl_r <= `VSC_RST_BYTE;
		end else if (do_write && w_lane_r) begin
			unique case (aw_idx_r)
				`VSC_IDX_CROP: crop_r <= w_byte_r;
				`VSC_IDX_VDL: vdl_r <= w_byte_r;
				`VSC_IDX_VAL: val_r <= w_byte_r;
				`VSC_IDX_HDL: hdl_r <= w_byte_r;
				`VSC_IDX_HAL: hal_r <= w_byte_r;
				`VSC_IDX_HRH: hrh_r <= w_byte_r;
				`VSC_IDX_HRL: hrl_r <= w_byte_r;
				`VSC_IDX_VRH: vrh_r <= w_byte_r;
				`VSC_IDX_VRL: vrl_r <= w_byte_r;
				`VSC_IDX_VTC: video_timing_ctrl_r <= w_byte_r;
				`VSC_IDX_SCL: subcarrier_loop_ctrl_r <= w_byte_r;
				default: ;
			endcase
		end
	end

	always_comb begin
		rd_word = 32'h0000_0000;
		rd_ok = 1'b1;
		unique case (araddr[7:2])
			`VSC_IDX_CROP: rd_word[7:0] = crop_r;
			`VSC_IDX_VDL: rd_word[7:0] = vdl_r;
			`VSC_IDX_VAL: rd_word[7:0] = val_r;
			`VSC_IDX_HDL: rd_word[7:0] = hdl_r;
			`VSC_IDX_HAL: rd_word[7:0] = hal_r;
			`VSC_IDX_HRH: rd_word[7:0] = hrh_r;
			`VSC_IDX_HRL: rd_word[7:0] = hrl_r;
			`VSC_IDX_VRH: rd_word[7:0] = vrh_r;
			`VSC_IDX_VRL: rd_word[7:0] = vrl_r;
			`VSC_IDX_VTC: rd_word[7:0] = video_timing_ctrl_r;
			`VSC_IDX_SCL: rd_word[7:0] = subcarrier_loop_ctrl_r;
			`VSC_IDX_STAT: rd_word = {14'h0000, line_keep_r, field_odd_r, 6'h00, vline_r};
			default: rd_ok = 1'b0;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready <= 1'b0;
			rvalid <= 1'b0;
			rdata <= 32'h0000_0000;
			rresp <= `VSC_RESP_OKAY;
		end else if (arvalid && arready) begin
			arready <= 1'b0;
			rvalid <= 1'b1;
			rdata <= rd_word;
			rresp <= rd_ok ? `VSC_RESP_OKAY : `VSC_RESP_SLVERR;
		end else if (rvalid && rready) begin
			rvalid <= 1'b0;
			arready <= 1'b1;
		end else if (!rvalid) begin
			arready <= 1'b1;
		end
	end

	// ****************************************
	// control decode
	// ****************************************
	logic [15:0] horiz_ratio_word;
	logic [12:0] vert_ratio_word, vmag;
	logic [9:0] hdel, hact, vdel, vact;
	logic [17:0] hstep;
	logic [14:0] vstep;
	logic [1:0] vert_tap_select, horiz_lowpass_select;
	vsc_pkg::vsc_vmode_type vmode;

	assign horiz_ratio_word = {hrh_r, hrl_r};
	assign vert_ratio_word = {vrh_r[`VSC_VRH_RATIO_MSB:0], vrl_r};
	assign vmag = 13'h0000 - vert_ratio_word;
	// input units per output unit; 16-bit ratio reaches 16:1 horizontally
	assign hstep = {2'b00, horiz_ratio_word} + `VSC_HUNIT;
	assign vstep = {2'b00, vmag} + `VSC_VUNIT;
	assign hdel = {crop_r[`VSC_CROP_HDL_MSB:`VSC_CROP_HDL_LSB], hdl_r};
	assign hact = {crop_r[`VSC_CROP_HAL_MSB:`VSC_CROP_HAL_LSB], hal_r};
	assign vdel = {crop_r[`VSC_CROP_VDL_MSB:`VSC_CROP_VDL_LSB], vdl_r};
	assign vact = {crop_r[`VSC_CROP_VAL_MSB:`VSC_CROP_VAL_LSB], val_r};
	assign vert_tap_select = video_timing_ctrl_r[`VSC_VTC_TAP_MSB:`VSC_VTC_TAP_LSB];
	assign horiz_lowpass_select = subcarrier_loop_ctrl_r[`VSC_SCL_HF_MSB:`VSC_SCL_HF_LSB];
	assign vmode = vrh_r[`VSC_VRH_INT_BIT] ? vsc_pkg::VSC_VM_INTERLACED :
		vrh_r[`VSC_VRH_ALIGN_BIT] ? vsc_pkg::VSC_VM_ALIGNED : vsc_pkg::VSC_VM_FRAME;

	// ****************************************
	// luma pre-filter and peaking
	// ****************************************
	logic [7:0] p0_r, p1_r, p2_r, pc0_r, pc1_r, pre_y;
	logic [10:0] e0, e1, e2, lp;
	logic signed [13:0] hpx, pk;
	logic a_valid_r, b_valid_r;
	vsc_pkg::vsc_pix_type b_pix_r, b_prev_r;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			a_valid_r <= 1'b0;
			p0_r <= 8'h00;
			p1_r <= 8'h00;
			p2_r <= 8'h00;
			pc0_r <= 8'h00;
			pc1_r <= 8'h00;
		end else begin
			a_valid_r <= in_valid;
			if (in_valid) begin
				p0_r <= in_pix.y;
				p1_r <= p0_r;
				p2_r <= p1_r;
				pc0_r <= in_pix.c;
				pc1_r <= pc0_r;
			end
		end
	end

	always_comb begin
		e0 = {3'b000, p0_r};
		e1 = {3'b000, p1_r};
		e2 = {3'b000, p2_r};
		lp = e1;
		hpx = {{2{1'b0}}, e1, 1'b0} - {3'b000, e0} - {3'b000, e2};
		// peak gain steps 1/8 .. 4/8 of the high-pass term; all signed so the shift keeps sign
		pk = $signed({6'h00, p1_r})
			+ ((hpx * $signed({12'h000, horiz_lowpass_select}) + hpx) >>> 3);
		unique case (horiz_lowpass_select)
			2'd0: lp = e1;
			2'd1: lp = (e0 + {e1[8:0], 2'b00} + {e1[9:0], 1'b0} + e2) >> 3;
			2'd2: lp = (e0 + {e1[9:0], 1'b0} + e2) >> 2;
			2'd3: lp = (e0 + {e0[9:0], 1'b0} + {e1[9:0], 1'b0} + e2 + {e2[9:0], 1'b0}) >> 3;
		endcase
		if (!subcarrier_loop_ctrl_r[`VSC_SCL_PEAK_BIT]) begin
			pre_y = lp[7:0];
		end else if (pk < 0) begin
			pre_y = 8'h00;
		end else if (pk > 14'sd255) begin
			pre_y = 8'hFF;
		end else begin
			pre_y = pk[7:0];
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			b_valid_r <= 1'b0;
			b_pix_r <= '{y: 8'h00, c: 8'h00};
		end else begin
			b_valid_r <= a_valid_r;
			if (a_valid_r) begin
				b_pix_r <= '{y: pre_y, c: pc1_r};
			end
		end
	end

	// ****************************************
	// horizontal poly-phase interpolation
	// ****************************************
	logic [17:0] hacc_r;
	logic [10:0] hcnt_r, c_hcnt_r;
	logic [4:0] hph;
	logic emit, c_valid_r;
	vsc_pkg::vsc_pix_type c_pix_r;

	function automatic logic [7:0] vsc_lerp32(input logic [7:0] a, input logic [7:0] b,
		input logic [4:0] ph);
		logic [13:0] sum;
		sum = {6'h00, a} * {8'h00, 6'd32 - {1'b0, ph}} + {6'h00, b} * {8'h00, 1'b0, ph};
		return sum[12:5];
	endfunction : vsc_lerp32

	assign emit = hacc_r < `VSC_HUNIT;
	assign hph = hacc_r[11:7];

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			hacc_r <= 18'h0_0000;
			hcnt_r <= 11'h000;
			c_valid_r <= 1'b0;
			c_hcnt_r <= 11'h000;
		end else begin
			c_valid_r <= b_valid_r && emit;
			if (line_start_strobe) begin
				hacc_r <= 18'h0_0000;
				hcnt_r <= 11'h000;
			end else if (b_valid_r) begin
				hacc_r <= emit ? hacc_r + hstep - `VSC_HUNIT : hacc_r - `VSC_HUNIT;
				if (emit && hcnt_r != `VSC_HCNT_MAX) begin
					hcnt_r <= hcnt_r + 11'h001;
				end
			end
			if (b_valid_r && emit) begin
				c_hcnt_r <= hcnt_r;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			b_prev_r <= '{y: 8'h00, c: 8'h00};
			c_pix_r <= '{y: 8'h00, c: 8'h00};
		end else begin
			if (b_valid_r) begin
				b_prev_r <= b_pix_r;
			end
			if (b_valid_r && emit) begin
				c_pix_r.y <= vsc_lerp32(b_prev_r.y, b_pix_r.y, hph);
				c_pix_r.c <= vsc_lerp32(b_prev_r.c, b_pix_r.c, hph);
			end
		end
	end

	// ****************************************
	// vertical line timing and window
	// ****************************************
	logic [14:0] vacc_r;
	logic [3:0] vph_r;
	logic [10:0] vhalf, hend, vend;
	logic hwin, vwin;
	logic [14:0] vstart;

	// odd field starts half an input line later so both fields line up
	assign vstart = (vmode == vsc_pkg::VSC_VM_ALIGNED && field_odd) ?
		`VSC_VHALF : 15'h0000;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			vacc_r <= 15'h0000;
			vph_r <= 4'h0;
			vline_r <= 10'h000;
			line_keep_r <= 1'b0;
			field_odd_r <= 1'b0;
		end else if (field_start_strobe) begin
			field_odd_r <= field_odd;
			vline_r <= 10'h000;
			// first line of the field starts with this strobe, so it is stepped here
			line_keep_r <= 1'b1;
			vph_r <= vstart[8:5];
			vacc_r <= vstart + vstep - `VSC_VUNIT;
		end else if (line_start_strobe) begin
			if (vline_r != `VSC_VLINE_MAX) begin
				vline_r <= vline_r + 10'h001;
			end
			line_keep_r <= vacc_r < `VSC_VUNIT;
			vph_r <= vacc_r[8:5];
			vacc_r <= (vacc_r < `VSC_VUNIT) ? vacc_r + vstep - `VSC_VUNIT : vacc_r - `VSC_VUNIT;
		end
	end

	assign vhalf = {vline_r, 1'b0};
	assign hend = {1'b0, hdel} + {1'b0, hact};
	assign vend = {1'b0, vdel} + {1'b0, vact};
	assign hwin = c_hcnt_r >= {1'b0, hdel} && c_hcnt_r < hend;
	assign vwin = vhalf >= {1'b0, vdel} && vhalf < vend;

	// ****************************************
	// line stores, vertical filter and output
	// ****************************************
	logic [7:0] ls_src [`VSC_LS_LINES + 1];
	logic [7:0] rd_y [`VSC_LS_LINES];
	logic [7:0] rd_c;
	logic [7:0] ls_c [`VSC_LS_DEPTH];
	logic [11:0] y0, y1, y2, y3, y4, tapf, vf;
	logic [7:0] vy, vc;

	assign ls_src[0] = c_pix_r.y;
	assign rd_c = ls_c[c_hcnt_r];

	for (genvar k = 0; k < `VSC_LS_LINES; k++) begin : g_line
		logic [7:0] mem [`VSC_LS_DEPTH];
		assign rd_y[k] = mem[c_hcnt_r];
		assign ls_src[k + 1] = rd_y[k];
		always_ff @(posedge aclk) begin
			if (c_valid_r) begin
				mem[c_hcnt_r] <= ls_src[k];
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (c_valid_r) begin
			ls_c[c_hcnt_r] <= c_pix_r.c;
		end
	end

	always_comb begin
		y0 = {4'h0, c_pix_r.y};
		y1 = {4'h0, rd_y[0]};
		y2 = {4'h0, rd_y[1]};
		y3 = {4'h0, rd_y[2]};
		y4 = {4'h0, rd_y[3]};
		unique case (vert_tap_select)
			2'd0: tapf = (y0 + y1) >> 1;
			2'd1: tapf = (y0 + {y1[10:0], 1'b0} + y2) >> 2;
			2'd2: tapf = (y0 + 12'(y1 * 2'd3) + 12'(y2 * 2'd3) + y3) >> 3;
			2'd3: tapf = (y0 + {y1[9:0], 2'b00} + 12'(y2 * 3'd6) + {y3[9:0], 2'b00} + y4) >> 4;
		endcase
		unique case (vmode)
			vsc_pkg::VSC_VM_FRAME: vf = tapf;
			vsc_pkg::VSC_VM_ALIGNED: vf = tapf;
			vsc_pkg::VSC_VM_INTERLACED: vf = field_odd_r ? (y0 + y1) >> 1 : y0;
			default: vf = y0;
		endcase
		vy = 8'(((vf * (5'd16 - {1'b0, vph_r})) + (y1 * {1'b0, vph_r})) >> 4);
		vc = 8'(({4'h0, c_pix_r.c} + {4'h0, rd_c}) >> 1);
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			out_pix <= '{y: 8'h00, c: 8'h00};
			out_valid <= 1'b0;
			out_line_start <= 1'b0;
			out_field_start <= 1'b0;
		end else begin
			out_valid <= c_valid_r && line_keep_r && hwin && vwin;
			out_line_start <= line_start_strobe;
			out_field_start <= field_start_strobe;
			if (c_valid_r) begin
				out_pix <= '{y: vy, c: vc};
			end
		end
	end

	// ****************************************
	// checks
	// ****************************************
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	AST_UNITY_EVERY_PIXEL: assert property (
		(horiz_ratio_word == 16'h0000 && b_valid_r && !line_start_strobe) |=> c_valid_r)
		else $error("unscaled input pixel produced no output pixel");
	AST_HALF_RATE_GAP: assert property (
		(horiz_ratio_word >= 16'h1000 && c_valid_r && !$past(line_start_strobe)) |-> !$past(c_valid_r))
		else $error("two outputs in a row at 2:1 or more");
	AST_LUMA_BETWEEN: assert property (
		c_valid_r |-> (c_pix_r.y >= $past(b_prev_r.y) || c_pix_r.y >= $past(b_pix_r.y))
		&& (c_pix_r.y <= $past(b_prev_r.y) || c_pix_r.y <= $past(b_pix_r.y)))
		else $error("luma interpolation outside its two neighbours");
	AST_CHROMA_BETWEEN: assert property (
		c_valid_r |-> (c_pix_r.c >= $past(b_prev_r.c) || c_pix_r.c >= $past(b_pix_r.c))
		&& (c_pix_r.c <= $past(b_prev_r.c) || c_pix_r.c <= $past(b_pix_r.c)))
		else $error("chroma interpolation outside its two neighbours");
	AST_LINE_RESTART: assert property (
		line_start_strobe |=> hcnt_r == 11'h000 && hacc_r == 18'h0_0000)
		else $error("line start did not clear the pixel count");
	AST_FIELD_RESTART: assert property (
		field_start_strobe |=> vline_r == 10'h000)
		else $error("field start did not clear the line count");
	AST_NO_SCALE_KEEPS: assert property (
		(vert_ratio_word == 13'h0000 && line_start_strobe && !field_start_strobe
		&& $past(vert_ratio_word) == 13'h0000 && vacc_r == 15'h0000) |=> line_keep_r)
		else $error("zero vertical ratio dropped a line");
	AST_DROPPED_SILENT: assert property (
		(c_valid_r && !line_keep_r) |=> !out_valid)
		else $error("dropped line reached the output");
	AST_WINDOW_ONLY: assert property (
		out_valid |-> $past(c_hcnt_r) >= {1'b0, $past(hdel)} && $past(c_hcnt_r) < $past(hend)
		&& $past(vhalf) >= {1'b0, $past(vdel)})
		else $error("pixel outside the window marked valid");

endmodule : vsc_scaler

/* File: tb/tb_top.sv */
// self-checking bench of the video scaler and cropper
`timescale 1ns/10ps
`include "vsc_defs.svh"
module tb_top;
	localparam int NPIX = 40;
	localparam int NLINE = 8;
	localparam int LIMIT = 40000;
	localparam logic [1:0] RSP_OK = `VSC_RESP_OKAY;
	localparam logic [1:0] RSP_ERR = `VSC_RESP_SLVERR;
	logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready, in_valid, ls, fs, fodd, out_valid;
	logic go, odd, slow, busy, cnt_en, chk_en;
	logic ols, ofs;
	logic ls_d = 1'b0;
	logic fs_d = 1'b0;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp;
	logic [15:0] seed;
	vsc_pkg::vsc_pix_type in_pix, out_pix, pix;
	int err_count, compares, vcount, cyc;
	logic [5:0] regs [11] = '{`VSC_IDX_CROP, `VSC_IDX_VDL, `VSC_IDX_VAL, `VSC_IDX_HDL,
		`VSC_IDX_HAL, `VSC_IDX_HRH, `VSC_IDX_HRL, `VSC_IDX_VRH, `VSC_IDX_VRL,
		`VSC_IDX_VTC, `VSC_IDX_SCL};
	logic [7:0] vmode [3] = '{8'h00, 8'h20, 8'h40};
	logic [7:0] scl [4] = '{8'h00, 8'h18, 8'h80, 8'h98};

	vsc_scaler dut_u (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
		.awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
		.arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
		.in_valid(in_valid), .in_pix(in_pix), .line_start_strobe(ls),
		.field_start_strobe(fs), .field_odd(fodd), .out_pix(out_pix),
		.out_valid(out_valid), .out_line_start(ols), .out_field_start(ofs));

	vsc_video_src #(.NPIX(NPIX), .NLINE(NLINE)) src_u (.aclk(aclk), .go(go), .odd(odd),
		.slow(slow), .pix(pix), .busy(busy), .in_valid(in_valid), .in_pix(in_pix),
		.line_start_strobe(ls), .field_start_strobe(fs), .field_odd(fodd));

	initial begin
		aclk = 1'b0;
		forever #20 aclk = ~aclk;
	end

	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction : lfsr

	// kept lines every vdiv, scaled pixels NPIX/hdiv, window in half lines and scaled pixels
	function automatic int exp_cnt(input int hd, ha, vd, va, hdiv, vdiv);
		int n = 0;
		for (int l = 0; l < NLINE; l += vdiv)
			for (int p = 0; p < NPIX / hdiv; p++)
				if (2 * l >= vd && 2 * l < vd + va && p >= hd && p < hd + ha) n++;
		return n;
	endfunction : exp_cnt

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			err_count++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic test_done;
		$display("errors=%0d compares=%0d", err_count, compares);
		if (err_count == 0 && compares > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : test_done

	task automatic wr(input logic [5:0] idx, input logic [7:0] d, input logic [1:0] er);
		awaddr <= {idx, 2'b00};
		wdata <= {24'h00_0000, d};
		wstrb <= 4'hF;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (awvalid && awready === 1'b1) awvalid <= 1'b0;
			if (wvalid && wready === 1'b1) wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		bready <= 1'b0;
		chk({30'h0, bresp}, {30'h0, er});
		@(posedge aclk);
	endtask : wr

	task automatic rd(input logic [5:0] idx, input logic [31:0] ed, input logic [1:0] er);
		araddr <= {idx, 2'b00};
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (arvalid && arready === 1'b1) arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		rready <= 1'b0;
		chk(rdata, ed);
		chk({30'h0, rresp}, {30'h0, er});
		@(posedge aclk);
	endtask : rd

	task automatic run_field(input logic o, input logic s);
		odd <= o;
		slow <= s;
		go <= 1'b1;
		@(posedge aclk);
		go <= 1'b0;
		@(posedge aclk);
		while (busy) @(posedge aclk);
		repeat (10) @(posedge aclk);
	endtask : run_field

	task automatic win(input int hd, ha, vd, va, hdiv, vdiv);
		logic [9:0] h, a, v, t;
		h = hd[9:0];
		a = ha[9:0];
		v = vd[9:0];
		t = va[9:0];
		wr(`VSC_IDX_CROP, {v[9:8], t[9:8], h[9:8], a[9:8]}, RSP_OK);
		wr(`VSC_IDX_HDL, h[7:0], RSP_OK);
		wr(`VSC_IDX_HAL, a[7:0], RSP_OK);
		wr(`VSC_IDX_VDL, v[7:0], RSP_OK);
		wr(`VSC_IDX_VAL, t[7:0], RSP_OK);
		vcount = 0;
		cnt_en = 1'b1;
		run_field(1'b0, seed[0]);
		cnt_en = 1'b0;
		chk(vcount, exp_cnt(hd, ha, vd, va, hdiv, vdiv));
	endtask : win

	always @(posedge aclk) begin
		if (cnt_en && out_valid === 1'b1) vcount++;
		// constant field: every tap setting, filter settings 0 and 3 and peaking at 1/8 and 4/8 must keep flat level
		if (chk_en && out_valid === 1'b1) begin
			chk({16'h0, out_pix}, {16'h0, pix});
		end
	end

	// output strobes trail the input strobes by one clock
	always @(posedge aclk) begin
		if (aresetn && (ls_d || fs_d || ols || ofs)) begin
			chk({30'h0, ols, ofs}, {30'h0, ls_d, fs_d});
		end
		ls_d <= ls;
		fs_d <= fs;
	end

	always @(posedge aclk) begin
		cyc++;
		if (cyc >= LIMIT) begin
			err_count++;
			test_done;
		end
	end

	initial begin
		{awvalid, wvalid, bready, arvalid, rready, go, odd, slow, cnt_en, chk_en} = '0;
		awaddr = 8'h00;
		araddr = 8'h00;
		wdata = 32'h0000_0000;
		wstrb = 4'h0;
		pix = '0;
		aresetn = 1'b0;
		seed = 16'h3E45;
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (2) @(posedge aclk);
		for (int i = 0; i < 11; i++) rd(regs[i], 32'h0000_0000, RSP_OK);
		for (int i = 0; i < 11; i++) begin
			seed = lfsr(seed);
			wr(regs[i], seed[7:0], RSP_OK);
			rd(regs[i], {24'h00_0000, seed[7:0]}, RSP_OK);
		end
		wr(6'h00, 8'h5A, RSP_ERR);
		rd(6'h00, 32'h0000_0000, RSP_ERR);
		wr(`VSC_IDX_STAT, 8'hFF, RSP_ERR);
		for (int i = 0; i < 11; i++) wr(regs[i], 8'h00, RSP_OK);
		win(0, 0, 0, 0, 1, 1);
		win(NPIX - 1, 1, 2 * NLINE - 2, 2, 1, 1);
		win(0, 1023, 0, 1023, 1, 1);
		for (int k = 0; k < 6; k++) begin
			seed = lfsr(seed);
			win(seed[4:0], seed[10:5] + 1, {seed[13:11], 1'b0}, seed[15:12] + 1, 1, 1);
		end
		wr(`VSC_IDX_HRH, 8'h10, RSP_OK);
		win(2, 100, 0, 1023, 2, 1);
		wr(`VSC_IDX_HRH, 8'h00, RSP_OK);
		wr(`VSC_IDX_VRH, 8'hA0, RSP_OK);
		wr(`VSC_IDX_VRH, (8'hA0 & 8'hE0) | 8'h1E, RSP_OK);
		wr(`VSC_IDX_VRL, 8'h00, RSP_OK);
		rd(`VSC_IDX_VRH, 32'h0000_00BE, RSP_OK);
		wr(`VSC_IDX_VRH, 8'h1E, RSP_OK);
		win(0, 1023, 0, 1023, 1, 2);
		// last line 7 of a 2:1 even field is dropped
		rd(`VSC_IDX_STAT, 32'h0000_0007, RSP_OK);
		for (int m = 0; m < 3; m++) begin
			for (int t = 0; t < 4; t++) begin
				seed = lfsr(seed);
				pix <= seed;
				wr(`VSC_IDX_VRH, vmode[m], RSP_OK);
				wr(`VSC_IDX_VTC, t[7:0], RSP_OK);
				wr(`VSC_IDX_SCL, scl[t], RSP_OK);
				run_field(1'b0, t[0]);
				chk_en = 1'b1;
				run_field(1'b1, t[1]);
				chk_en = 1'b0;
			end
		end
		test_done;
	end
endmodule : tb_top

/* File: tb/vsc_video_src.sv */
// upstream decoder model: one field of lines of pixels with line and field strobes
`timescale 1ns/10ps
module vsc_video_src #(
	parameter int NPIX = 40,
	parameter int NLINE = 8
) (
	input wire logic aclk,
	input wire logic go,
	input wire logic odd,
	input wire logic slow,
	input wire vsc_pkg::vsc_pix_type pix,
	output logic busy,
	output logic in_valid,
	output vsc_pkg::vsc_pix_type in_pix,
	output logic line_start_strobe,
	output logic field_start_strobe,
	output logic field_odd
);
	initial begin
		busy = 1'b0;
		in_valid = 1'b0;
		in_pix = '0;
		line_start_strobe = 1'b0;
		field_start_strobe = 1'b0;
		field_odd = 1'b0;
		forever begin
			@(posedge aclk);
			if (go) begin
				busy <= 1'b1;
				field_odd <= odd;
				for (int l = 0; l < NLINE; l++) begin
					line_start_strobe <= 1'b1;
					field_start_strobe <= (l == 0);
					@(posedge aclk);
					line_start_strobe <= 1'b0;
					field_start_strobe <= 1'b0;
					repeat (2) @(posedge aclk);
					for (int p = 0; p < NPIX; p++) begin
						in_valid <= 1'b1;
						in_pix <= pix;
						@(posedge aclk);
						if (slow) begin
							// idle cycle shows a changed pattern, not the last pixel
							in_valid <= 1'b0;
							in_pix <= vsc_pkg::vsc_pix_type'(~pix);
							@(posedge aclk);
						end
					end
					in_valid <= 1'b0;
					in_pix <= vsc_pkg::vsc_pix_type'(~pix);
					repeat (3) @(posedge aclk);
				end
				busy <= 1'b0;
			end
		end
	end
endmodule : vsc_video_src
